// [hw/fcp_defines.vh]
`ifndef FCP_DEFINES_VH
`define FCP_DEFINES_VH

// Register byte offsets on the APB bus.
`define FCP_REG_IN_IMAGE     8'h00
`define FCP_REG_OUT_IMAGE    8'h04
`define FCP_REG_SYS_CTRL     8'h08
`define FCP_REG_CNT_BASE     8'h10
`define FCP_REG_CNT_STRIDE   8'h08
`define FCP_REG_CNT_CTRL     8'h00
`define FCP_REG_CNT_VALUE    8'h04
`define FCP_REG_PLS_BASE     8'h20
`define FCP_REG_PLS_STRIDE   8'h10
`define FCP_REG_PLS_CTRL     8'h00
`define FCP_REG_PLS_PERIOD   8'h04
`define FCP_REG_PLS_WIDTH    8'h08
`define FCP_REG_PLS_COUNT    8'h0C

// Counter control fields.
`define FCP_CNT_SETUP_BIT    0
`define FCP_CNT_QUAD_BIT     1
`define FCP_CNT_HWDIR_BIT    2
`define FCP_CNT_DOWN_BIT     3

// Pulse control fields.
`define FCP_PLS_SETUP_BIT    0
`define FCP_PLS_START_BIT    1
`define FCP_PLS_TRAIN_BIT    2

// System control fields.
`define FCP_SYS_CARD_BIT     0

// Pin positions of the digital inputs and outputs.
`define FCP_QUAD_B_ZERO      4
`define FCP_COUNT_PIN_ZERO   20
`define FCP_PULSE_OUT_ZERO   20
`define FCP_QUAD_B_ONE       5
`define FCP_COUNT_PIN_ONE    22
`define FCP_PULSE_OUT_ONE    21

// Reset values.
`define FCP_RST_WORD         32'h0000_0000

// Timing: clock period and generator time base.
`define FCP_CLK_NS           10
`define FCP_TICK_NS          1000
`define FCP_TICK_CYCLES      ((`FCP_TICK_NS + `FCP_CLK_NS - 1) / `FCP_CLK_NS)
`define FCP_PWM_MIN_US       2
`define FCP_PWM_MIN_TICKS    ((`FCP_PWM_MIN_US * 1000) / `FCP_TICK_NS)
`define FCP_TRAIN_BATCH      8'hFF

`endif

// [hw/fcp_pulse_gen.v]
`timescale 1ns/1ps
`default_nettype none
`include "fcp_defines.vh"

module fcp_pulse_gen (
    input  wire        pclk,     // Module clock.
    input  wire        presetn,  // Asynchronous reset, active low.
    input  wire        tick,     // One-cycle time-base enable, once per microsecond.
    input  wire        setup,    // One-cycle setup pulse that latches the parameters.
    input  wire        start,    // Level: generator enabled by software.
    input  wire        train,    // Mode: 1 pulse train, 0 PWM.
    input  wire [31:0] period,   // Period in ticks.
    input  wire [31:0] width,    // High time in ticks.
    input  wire [31:0] count,    // Number of pulses for a train.
    output reg         ready,    // Parameters have been latched.
    output reg         active,   // Generator owns the output.
    output reg         done,     // Train finished since last setup.
    output reg         pulse     // Generated waveform.
);

    //////////////////////////////////////////////////////////////////////////
    // Latched parameters and running state.
    reg        train_l;     // Latched mode.
    reg [31:0] period_l;    // Latched period, clamped to the legal minimum.
    reg [31:0] width_l;     // Latched high time.
    reg [31:0] remain;      // Pulses still to load into the batch counter.
    reg [7:0]  batch;       // Pulses left in the present batch.
    reg [31:0] timer;       // Position within the current period.
    wire [31:0] span;       // Period in the active resolution.
    wire        wrap;       // Last tick of the period.

    // The pulse train runs on a 16-bit timer, PWM on the full 32 bits.
    assign span = train_l ? {16'h0000, period_l[15:0]} : period_l; // [R11] [R12]
    assign wrap = tick && (timer + 32'h0000_0001 >= span);

    // Splits a pulse count into one batch and the remainder, as {remain, batch}.
    function [39:0] split;
        input [31:0] n;
        begin
            if (n > {24'h00_0000, `FCP_TRAIN_BATCH})
                split = {n - {24'h00_0000, `FCP_TRAIN_BATCH}, `FCP_TRAIN_BATCH};
            else
                split = {`FCP_RST_WORD, n[7:0]};
        end
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // Setup, start, period timing and train batch reloading.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ready    <= 1'b0;
            active   <= 1'b0;
            done     <= 1'b0;
            pulse    <= 1'b0;
            train_l  <= 1'b0;
            period_l <= `FCP_RST_WORD;
            width_l  <= `FCP_RST_WORD;
            remain   <= `FCP_RST_WORD;
            batch    <= 8'h00;
            timer    <= `FCP_RST_WORD;
        end
        else if (setup)
        begin
            // Setup stops the generator and takes new parameters.
            ready    <= 1'b1; // [R7]
            active   <= 1'b0;
            done     <= 1'b0;
            pulse    <= 1'b0;
            train_l  <= train;
            period_l <= (period < `FCP_PWM_MIN_TICKS) ? `FCP_PWM_MIN_TICKS : period; // [R11]
            width_l  <= width;
            {remain, batch} <= split(count);
            timer    <= `FCP_RST_WORD;
        end
        else if (!start || !ready)
        begin
            // Disabled: the output image owns the pin again.
            active <= 1'b0; // [R9]
            pulse  <= 1'b0;
            timer  <= `FCP_RST_WORD;
        end
        else if (!done)
        begin
            if (train_l && batch == 8'h00)
            begin
                // Train with nothing left (or a zero count) ends at once.
                active <= 1'b0;
                done   <= 1'b1;
                pulse  <= 1'b0;
            end
            else
            begin
                active <= 1'b1; // [R8]
                pulse  <= (timer < width_l);
                if (wrap)
                begin
                    timer <= `FCP_RST_WORD;
                    if (train_l)
                    begin
                        // Reload the batch counter for trains beyond one batch.
                        {remain, batch} <= (batch == 8'h01 && remain != `FCP_RST_WORD)
                                           ? split(remain) : {remain, batch - 8'h01}; // [R10]
                    end
                end
                else if (tick)
                begin
                    timer <= timer + 32'h0000_0001;
                end
            end
        end
    end

endmodule // fcp_pulse_gen

`default_nettype wire

// [hw/fcp_top.v]
`timescale 1ns/1ps
`default_nettype none
`include "fcp_defines.vh"

// Operation
// R1: Two counters, set up, then value readable.
// R2: Direction latched once at setup only.
// R3: Counter inputs accepted up to 24 MHz.
// R4: Quadrature X4 mode with fixed B inputs.
// R5: Quadrature B input reads zero in image.
// R6: Card mode disables hardware direction, channel zero.
// R7: Two pulse generators, set up before output.
// R8: Running generator drives its assigned output.
// R9: Stopped generator returns output to image.
// R10: Trains beyond 255 pulses reload batch count.
// R11: PWM 32-bit, period from 2 us.
// R12: Pulse train uses 16-bit timer.
// R13: Image bits are not inverted.
// R14: Counter value signed 32-bit two's complement.
// R15: Quadrature counts every edge, phase gives direction.
// R16: Count and direction pins per channel fixed.

module fcp_top (
    input  wire        pclk,     // Module clock, 100 MHz.
    input  wire        presetn,  // Asynchronous reset, active low.
    input  wire        psel,     // APB select.
    input  wire        penable,  // APB access phase.
    input  wire        pwrite,   // APB direction, 1 write.
    input  wire [7:0]  paddr,    // APB byte address.
    input  wire [31:0] pwdata,   // APB write data.
    output reg  [31:0] prdata,   // APB read data.
    output wire        pready,   // APB ready, always high.
    output wire        pslverr,  // APB error on unmapped address.
    input  wire [23:0] din,      // Digital input pins.
    output reg  [21:0] dout      // Digital output pins.
);

    //////////////////////////////////////////////////////////////////////////
    // Address decode helper.
    function hit;
        input [7:0] addr;
        input [7:0] off;
        begin
            hit = (addr == off);
        end
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // Bus strobes. Transfers complete with no wait states.
    wire       wr_en;      // Write takes effect in the access phase.
    wire       rd_setup;   // Read data is fetched in the setup phase.
    wire       mapped;     // Address belongs to a register.

    assign pready   = 1'b1;
    assign wr_en    = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign mapped   = hit(paddr, `FCP_REG_IN_IMAGE) || hit(paddr, `FCP_REG_OUT_IMAGE)
                   || hit(paddr, `FCP_REG_SYS_CTRL)
                   || (paddr[7:4] == 4'h1 && paddr[1:0] == 2'b00)
                   || (paddr[7:5] == 3'b001 && paddr[1:0] == 2'b00);
    assign pslverr  = psel && penable && !mapped;

    //////////////////////////////////////////////////////////////////////////
    // Input synchronisers. Stage one feeds stage two only; stage three
    // keeps the previous sample for edge detection.
    reg [23:0] din_s1;     // First synchroniser stage.
    reg [23:0] din_s2;     // Second synchroniser stage.
    reg [23:0] din_s3;     // Previous settled sample.

    // At 100 MHz a 24 MHz input gives at least two samples per level.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            din_s1 <= 24'h00_0000;
            din_s2 <= 24'h00_0000;
            din_s3 <= 24'h00_0000;
        end
        else
        begin
            din_s1 <= din; // [R3]
            din_s2 <= din_s1;
            din_s3 <= din_s2;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Output image and system control registers.
    reg [21:0] out_image;  // Software output image.
    reg        card_mode;  // Memory-card mode enable.

    // Plain stores from the bus.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_image <= 22'h00_0000;
            card_mode <= 1'b0;
        end
        else if (wr_en)
        begin
            if (hit(paddr, `FCP_REG_OUT_IMAGE))
            begin
                out_image <= pwdata[21:0];
            end
            if (hit(paddr, `FCP_REG_SYS_CTRL))
            begin
                card_mode <= pwdata[`FCP_SYS_CARD_BIT];
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Microsecond time base for the pulse generators.
    reg [7:0] tick_cnt;    // Divider count.
    reg       tick;        // One-cycle enable pulse.

    // Divides the clock down to one enable per microsecond.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_cnt <= 8'h00;
            tick     <= 1'b0;
        end
        else if (tick_cnt == (`FCP_TICK_CYCLES - 1))
        begin
            tick_cnt <= 8'h00;
            tick     <= 1'b1;
        end
        else
        begin
            tick_cnt <= tick_cnt + 8'h01;
            tick     <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Counter channels.
    wire [63:0] cnt_value;  // Both counter values.
    wire [63:0] cnt_status; // Both counter control readbacks.
    wire [1:0]  quad_on;    // Quadrature mode per channel.

    genvar gc;
    generate
        for (gc = 0; gc < 2; gc = gc + 1)
        begin : g_cnt
            localparam [4:0] APIN = (gc == 0) ? `FCP_COUNT_PIN_ZERO : `FCP_COUNT_PIN_ONE;
            localparam [4:0] BPIN = (gc == 0) ? `FCP_QUAD_B_ZERO : `FCP_QUAD_B_ONE;
            localparam [7:0] CBASE = `FCP_REG_CNT_BASE + gc * `FCP_REG_CNT_STRIDE;
            reg        running;   // Channel has been set up.
            reg        quad;      // Quadrature mode latched at setup.
            reg        hwdir;     // Hardware direction chosen at setup.
            reg        down;      // Latched direction, 1 counts down.
            reg [31:0] value;     // Signed count.
            wire       a_now;     // Settled A level.
            wire       a_old;     // Previous A level.
            wire       b_now;     // Settled B level.
            wire       b_old;     // Previous B level.
            wire       dir_pin;   // Settled direction pin.
            reg        step;      // Count in this cycle.
            reg        step_dn;   // Raw step is downward.

            assign a_now   = din_s2[APIN];
            assign a_old   = din_s3[APIN];
            assign b_now   = din_s2[BPIN];
            assign b_old   = din_s3[BPIN];
            assign dir_pin = din_s2[APIN + 5'd1]; // [R16]

            // Step decode: single-input counting or X4 quadrature.
            always @*
            begin
                step    = 1'b0;
                step_dn = 1'b0;
                if (quad)
                begin
                    // Each edge of A or B steps once; B leading A counts down.
                    step    = (a_now ^ a_old) ^ (b_now ^ b_old) ? 1'b1 : 1'b0; // [R4] [R15]
                    step_dn = (a_now ^ a_old) ? (a_now == b_now) : (a_now != b_now); // [R15]
                end
                else
                begin
                    step = a_now && !a_old; // [R16]
                end
            end

            // Setup latches mode and direction; the count runs afterwards.
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    running <= 1'b0;
                    quad    <= 1'b0;
                    hwdir   <= 1'b0;
                    down    <= 1'b0;
                    value   <= `FCP_RST_WORD;
                end
                else if (wr_en && hit(paddr, CBASE + `FCP_REG_CNT_CTRL)
                         && pwdata[`FCP_CNT_SETUP_BIT])
                begin
                    running <= 1'b1; // [R1]
                    quad    <= pwdata[`FCP_CNT_QUAD_BIT];
                    value   <= `FCP_RST_WORD;
                    if (pwdata[`FCP_CNT_HWDIR_BIT] && !(gc == 0 && card_mode)) // [R6]
                    begin
                        hwdir <= 1'b1;
                        down  <= dir_pin; // [R2]
                    end
                    else
                    begin
                        hwdir <= 1'b0;
                        down  <= pwdata[`FCP_CNT_DOWN_BIT]; // [R2]
                    end
                end
                else if (running && step)
                begin
                    // Wraps through the full two's-complement range.
                    if (step_dn ^ down)
                    begin
                        value <= value - 32'h0000_0001; // [R14]
                    end
                    else
                    begin
                        value <= value + 32'h0000_0001; // [R14]
                    end
                end
            end

            assign cnt_value[gc*32 +: 32]  = value;
            assign cnt_status[gc*32 +: 32] = {22'h00_0000, down, running, 4'h0,
                                              down, hwdir, quad, 1'b0};
            assign quad_on[gc] = quad && running;
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////
    // Pulse generator channels.
    wire [1:0]  pls_pulse;  // Generated waveforms.
    wire [1:0]  pls_active; // Generator owns its output.
    wire [63:0] pls_status; // Control readbacks.
    wire [127:0] pls_regs;  // Period and width per channel.

    genvar gp;
    generate
        for (gp = 0; gp < 2; gp = gp + 1)
        begin : g_pls
            localparam [7:0] PBASE = `FCP_REG_PLS_BASE + gp * `FCP_REG_PLS_STRIDE;
            reg [31:0] period;    // Period in microseconds.
            reg [31:0] width;     // High time in microseconds.
            reg [31:0] count;     // Pulse count for a train.
            reg        start;     // Software start level.
            reg        train;     // Pulse train mode select.
            reg        setup;     // One-cycle setup strobe.
            wire       ready;     // Parameters latched.
            wire       done;      // Train finished.

            // Parameter registers and the setup strobe.
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    period <= `FCP_RST_WORD;
                    width  <= `FCP_RST_WORD;
                    count  <= `FCP_RST_WORD;
                    start  <= 1'b0;
                    train  <= 1'b0;
                    setup  <= 1'b0;
                end
                else
                begin
                    setup <= 1'b0;
                    if (wr_en && hit(paddr, PBASE + `FCP_REG_PLS_PERIOD))
                        period <= pwdata;
                    if (wr_en && hit(paddr, PBASE + `FCP_REG_PLS_WIDTH))
                        width <= pwdata;
                    if (wr_en && hit(paddr, PBASE + `FCP_REG_PLS_COUNT))
                        count <= pwdata;
                    if (wr_en && hit(paddr, PBASE + `FCP_REG_PLS_CTRL))
                    begin
                        start <= pwdata[`FCP_PLS_START_BIT];
                        train <= pwdata[`FCP_PLS_TRAIN_BIT];
                        setup <= pwdata[`FCP_PLS_SETUP_BIT]; // [R7]
                    end
                end
            end

            fcp_pulse_gen u_gen (
                .pclk    (pclk),
                .presetn (presetn),
                .tick    (tick),
                .setup   (setup),
                .start   (start),
                .train   (train),
                .period  (period),
                .width   (width),
                .count   (count),
                .ready   (ready),
                .active  (pls_active[gp]),
                .done    (done),
                .pulse   (pls_pulse[gp])
            );

            assign pls_status[gp*32 +: 32] = {21'h00_0000, done, pls_active[gp], ready,
                                              5'h00, train, start, 1'b0};
            assign pls_regs[gp*64 +: 64]   = {width, period};
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////
    // Output pins: the image, with generator-owned bits overridden.
    // Image ones drive high; no inversion anywhere.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dout <= 22'h00_0000;
        end
        else
        begin
            dout <= out_image; // [R13] [R9]
            if (pls_active[0])
                dout[`FCP_PULSE_OUT_ZERO] <= pls_pulse[0]; // [R8]
            if (pls_active[1])
                dout[`FCP_PULSE_OUT_ONE] <= pls_pulse[1]; // [R8]
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Input image: settled levels, with quadrature B bits forced low.
    reg [23:0] in_image;   // Masked input image.

    always @*
    begin
        in_image = din_s2; // [R13]
        if (quad_on[0])
            in_image[`FCP_QUAD_B_ZERO] = 1'b0; // [R5]
        if (quad_on[1])
            in_image[`FCP_QUAD_B_ONE] = 1'b0; // [R5]
    end

    //////////////////////////////////////////////////////////////////////////
    // Read data is captured in the setup phase and held for the access.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= `FCP_RST_WORD;
        end
        else if (rd_setup)
        begin
            case (paddr)
                `FCP_REG_IN_IMAGE:  prdata <= {8'h00, in_image};
                `FCP_REG_OUT_IMAGE: prdata <= {10'h000, out_image};
                `FCP_REG_SYS_CTRL:  prdata <= {31'h0000_0000, card_mode};
                8'h10:              prdata <= cnt_status[31:0];
                8'h14:              prdata <= cnt_value[31:0]; // [R1]
                8'h18:              prdata <= cnt_status[63:32];
                8'h1C:              prdata <= cnt_value[63:32]; // [R1]
                8'h20:              prdata <= pls_status[31:0];
                8'h24:              prdata <= pls_regs[31:0];
                8'h28:              prdata <= pls_regs[63:32];
                8'h2C:              prdata <= g_pls[0].count;
                8'h30:              prdata <= pls_status[63:32];
                8'h34:              prdata <= pls_regs[95:64];
                8'h38:              prdata <= pls_regs[127:96];
                8'h3C:              prdata <= g_pls[1].count;
                default:            prdata <= `FCP_RST_WORD;
            endcase
        end
    end

endmodule // fcp_top

`default_nettype wire

// [tb/fcp_top_props.sv]
`timescale 1ns/1ps
`default_nettype none
module fcp_top_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [23:0] din,
    input wire logic [21:0] dout
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
wire logic acc = psel && penable;                   // Access phase.
wire logic bad = paddr == 8'h0C || paddr >= 8'h40;  // Unmapped place.
logic      img20;                                   // Image bit under pulse output zero.
// Tracks the image bit that the pin must fall back to.
always @(posedge pclk or negedge presetn)
    if (!presetn)
        img20 <= 1'b0;
    else if (acc && pwrite && paddr == 8'h04)
        img20 <= pwdata[20];
chk_ready_high: assert property (pready) else $error("pready low");
chk_bad_err: assert property (acc && bad |-> pslverr) else $error("no error");
chk_good_ok: assert property (acc && !bad |-> !pslverr) else $error("false error");
chk_bad_zero: assert property (acc && !pwrite && bad |-> prdata == '0)
    else $error("bad read data");
chk_out_image: assert property (acc && pwrite && paddr == 8'h04 |=> ##1
    dout[19:0] == $past(pwdata[19:0], 2)) else $error("image not driven");
chk_in_image: assert property ($stable(din[3:0]) [*3] ##0
    (psel && !penable && !pwrite && paddr == 8'h00) |=> prdata[3:0] == din[3:0])
    else $error("input image");
chk_pin_release: assert property (acc && pwrite && paddr == 8'h20 && !pwdata[1]
    |=> ##[1:2] dout[20] == img20) else $error("output not released");
chk_reset_clear: assert property ($rose(presetn) |-> dout == '0 && prdata == '0)
    else $error("reset values");
cov_write: cover property (acc && pwrite);
cov_count_rd: cover property (acc && paddr == 8'h14);
cov_train: cover property ($rose(dout[21]));
endmodule // fcp_top_props
bind fcp_top fcp_top_props chk_inst (.*);
`default_nettype wire

// [tb/fcp_enc_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Encoder stand-in: the phase walks one quadrature state per step.
module fcp_enc_model (
    input wire logic pclk, // Clock.
    input wire logic step, // Advance one state.
    input wire logic up,   // Forward when high.
    output logic     a,    // Channel A, leads when forward.
    output logic     b     // Channel B.
);
logic [1:0] ph = 2'h0; // Phase state.
always @(posedge pclk)
    if (step)
        ph <= up ? ph + 2'h1 : ph - 2'h1;
assign a = ph[1] ^ ph[0];
assign b = ph[1];
endmodule // fcp_enc_model
`default_nettype wire

// [tb/fast_counter_pulse_io_test.sv]
`timescale 1ns/1ps
`default_nettype none
module fast_counter_pulse_io_test;
logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
logic [7:0]  paddr = 0;
logic [31:0] pwdata = 0, prdata, rdat, v;
logic        pready, pslverr, err, a, b, step = 0, up = 1, dir0 = 0, dir1 = 1;
logic        p0q = 0, p1q = 0;
logic [21:0] dout;
wire logic [23:0] din = {dir1, a, dir0, a, 14'h0000, b, b, 4'h5}; // Pins.
int          n_errors = 0, n_compared = 0, rise0 = 0, rise1 = 0, i;
logic [72:0] rows [7] = '{{8'h04, 32'hFFFF_FFFF, 32'h003F_FFFF, 1'b0},
    {8'h04, 32'h0000_0000, 32'h0000_0000, 1'b0}, {8'h08, 32'h0000_0001, 32'h0000_0001, 1'b0},
    {8'h08, 32'h0000_0000, 32'h0000_0000, 1'b0}, {8'h00, 32'hFFFF_FFFF, 32'h0080_0005, 1'b0},
    {8'h0C, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1}, {8'h40, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1}};
always #5 pclk = ~pclk;
// Counts rising edges on both pulse outputs.
always @(posedge pclk)
begin
    p0q <= dout[20];
    p1q <= dout[21];
    rise0 += int'(dout[20] && !p0q);
    rise1 += int'(dout[21] && !p1q);
end
fcp_top fcp_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .din(din), .dout(dout));
fcp_enc_model fcp_enc_model_inst (.pclk(pclk), .step(step), .up(up), .a(a), .b(b));
task automatic wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
        $display("verification passed");
    else
        $display("verification failed");
    $finish;
endtask
task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
        $display("mismatch %s expected %h seen %h", nm, e, g);
    n_errors += int'(g !== e);
endtask
// One APB transfer; the request holds until pready is seen high.
task automatic xfer(input logic [7:0] ad, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int k = 0; k < 20; k++)
    begin
        @(posedge pclk);
        if (pready === 1'b1)
            break;
        if (k == 19)
            chk("pready", 32'h0000_0001, 32'h0000_0000);
        if (k == 19)
            wrap_up();
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask
task automatic rd_chk(input logic [7:0] ad, input logic [31:0] e, input string nm);
    xfer(ad, 1'b0, 32'h0000_0000);
    chk(nm, e, rdat);
endtask
// Walks the encoder n states slowly.
task automatic steps(input int n, input logic u);
    repeat (n)
    begin
        @(posedge pclk);
        step <= 1'b1;
        up <= u;
        @(posedge pclk);
        step <= 1'b0;
        repeat (3) @(posedge pclk);
    end
    repeat (5) @(posedge pclk);
endtask
initial
begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[j])
    begin
        xfer(rows[j][72:65], 1'b1, rows[j][64:33]);
        rd_chk(rows[j][72:65], rows[j][32:1], "register");
        chk("error", {31'h0000_0000, rows[j][0]}, {31'h0000_0000, err});
    end
    $display("register table done");
    xfer(8'h10, 1'b1, 32'h0000_0001);
    steps(20, 1'b1);
    rd_chk(8'h14, 32'h0000_0005, "count up");
    xfer(8'h10, 1'b1, 32'h0000_0009);
    steps(20, 1'b1);
    rd_chk(8'h14, 32'hFFFF_FFFB, "count down");
    xfer(8'h18, 1'b1, 32'h0000_0005);
    steps(12, 1'b1);
    xfer(8'h1C, 1'b0, 32'h0000_0000);
    v = rdat;
    chk("pin direction", 32'h0000_0003, v[31] ? -v : v);
    dir1 <= 1'b0;
    steps(12, 1'b1);
    rd_chk(8'h1C, v + v, "direction held");
    xfer(8'h08, 1'b1, 32'h0000_0001);
    for (i = 0; i < 2; i++)
    begin
        dir0 <= i[0];
        steps(0, 1'b1);
        xfer(8'h10, 1'b1, 32'h0000_000D);
        steps(12, 1'b1);
        rd_chk(8'h14, 32'hFFFF_FFFD, "card mode");
    end
    xfer(8'h10, 1'b1, 32'h0000_0003);
    steps(2, 1'b1);
    rd_chk(8'h00, 32'h0070_0025, "quad image");
    steps(2, 1'b1);
    rd_chk(8'h14, 32'h0000_0004, "quad up");
    steps(3, 1'b0);
    rd_chk(8'h14, 32'h0000_0001, "quad down");
    $display("counter tests done");
    xfer(8'h04, 1'b1, 32'h0010_0000);
    xfer(8'h24, 1'b1, 32'h0000_0004);
    xfer(8'h28, 1'b1, 32'h0000_0002);
    xfer(8'h20, 1'b1, 32'h0000_0001);
    xfer(8'h20, 1'b1, 32'h0000_0002);
    v = rise0;
    repeat (1000) @(posedge pclk);
    chk("pwm running", 32'h0000_0001, {31'h0000_0000, rise0 >= v + 2});
    xfer(8'h20, 1'b1, 32'h0000_0000);
    steps(0, 1'b1);
    chk("pin released", 32'h0000_0001, {31'h0000_0000, dout[20]});
    xfer(8'h34, 1'b1, 32'h0000_0002);
    xfer(8'h38, 1'b1, 32'h0000_0001);
    xfer(8'h3C, 1'b1, 32'h0000_012C);
    xfer(8'h30, 1'b1, 32'h0000_0005);
    v = rise1;
    xfer(8'h30, 1'b1, 32'h0000_0006);
    for (i = 0; i < 800 && rdat[10] !== 1'b1; i++)
    begin
        repeat (100) @(posedge pclk);
        xfer(8'h30, 1'b0, 32'h0000_0000);
    end
    chk("train state", 32'h0000_0005, {29'h0000_0000, rdat[10:8]});
    chk("train pulses", v + 32'h0000_012C, rise1);
    $display("pulse tests done");
    wrap_up();
end
endmodule // fast_counter_pulse_io_test
`default_nettype wire
